// ===== rtl/sfc_consts.svh
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH

`define SFC_CLK_MHZ        100
`define SFC_PH_RISE        3'h4
`define SFC_PH_LAST        3'h7
`define SFC_GAP_NS         50
`define SFC_GAP_CYC        ((`SFC_GAP_NS * `SFC_CLK_MHZ + 999) / 1000)
`define SFC_RECOV_US       28
`define SFC_RECOV_CYC      (`SFC_RECOV_US * `SFC_CLK_MHZ)

`define SFC_CODE_QUAD_ENTER 8'h38
`define SFC_CODE_QUAD_EXIT  8'hFF
`define SFC_CODE_RST_ARM    8'h66
`define SFC_CODE_RST_EXEC   8'h99
`define SFC_CODE_WL_SET     8'h06
`define SFC_CODE_WL_CLR     8'h04
`define SFC_CODE_ST_READ    8'h05
`define SFC_CODE_ST_WRITE   8'h01
`define SFC_CODE_ID_READ    8'h9F

`define SFC_ST_BUSY        0
`define SFC_ST_WLATCH      1
`define SFC_ST_PROT_LSB    2
`define SFC_ST_PROT_MSB    5
`define SFC_ST_PIN_DIS     6
`define SFC_ST_PROTECT     7
`define SFC_ST_RESET       8'h00

`define SFC_DQ_SINGLE_OE   4'hD
`define SFC_DQ_QUAD_OE     4'hF
`define SFC_DQ_IDLE        4'hC

`endif

// ===== rtl/sfc_pkg.sv
package sfc_pkg;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_GAP   = 5'h02,
    ST_SHIFT = 5'h04,
    ST_RECOV = 5'h08,
    ST_FIN   = 5'h10
  } sfc_state_e;

  typedef enum logic [3:0] {
    OP_QUAD_ENTER  = 4'h0,
    OP_QUAD_EXIT   = 4'h1,
    OP_RESET       = 4'h2,
    OP_RESET_BLIND = 4'h3,
    OP_WL_SET      = 4'h4,
    OP_WL_CLR      = 4'h5,
    OP_ST_READ     = 4'h6,
    OP_ST_WRITE    = 4'h7,
    OP_ID_READ     = 4'h8
  } sfc_op_e;

endpackage

// ===== rtl/sfc_ctrl.sv
// Contract
// - Quad exit frame returns to single-bit
// - Never send quad exit in single mode
// - Continuous read active: send exit twice
// - Reset needs arm then execute, separate frames
// - Wait 28 us recovery after reset
// - Reset pair sent in current width
// - Unknown mode: quad pair then single pair
// - Latch set sent alone in frame
// - Set latch before every status write
// - Poll busy flag clear before next command
`timescale 1ns/1ns
`include "sfc_consts.svh"

module sfc_ctrl
  import sfc_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        cmd_valid_i,
  input  wire sfc_op_e     cmd_op_i,
  input  wire logic [7:0]  cmd_data_i,
  input  wire logic        cont_read_i,
  output logic             cmd_ready_o,
  output logic             done_o,
  output logic             error_o,
  output logic [7:0]       status_o,
  output logic [23:0]      id_o,
  output logic             quad_mode_o,
  output logic             sck_o,
  output logic             cs_n_o,
  output logic [3:0]       dq_o,
  output logic [3:0]       dq_oe_o,
  input  wire logic [3:0]  dq_i
);

  logic [3:0]  dq_s1_r, dq_s2_r, dq_s3_r;
  logic [3:0]  dq_f_r, dq_f_nxt;
  sfc_state_e  state_r, state_nxt;
  sfc_op_e     op_r, op_nxt;
  logic [1:0]  step_r, step_nxt;
  logic [2:0]  ph_r, ph_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic [2:0]  bi_r, bi_nxt;
  logic [7:0]  tsr_r, tsr_nxt;
  logic [7:0]  rsr_r, rsr_nxt;
  logic [11:0] wait_r, wait_nxt;
  logic [7:0]  wdat_r, wdat_nxt;
  logic        cont_r, cont_nxt;
  logic        bad_r, bad_nxt;
  logic        quad_r, quad_nxt;
  logic [7:0]  stat_r, stat_nxt;
  logic [23:0] id_r, id_nxt;
  logic        ready_r, ready_nxt;
  logic        done_r, done_nxt;
  logic        err_r, err_nxt;
  logic        sck_r, sck_nxt;
  logic        cs_n_r, cs_n_nxt;
  logic [3:0]  dqo_r, dqo_nxt;
  logic [3:0]  dqoe_r, dqoe_nxt;

  logic [7:0]  f_code, byte_in;
  logic [2:0]  f_nby;
  logic        f_quad, f_two, f_poll, f_wait, f_last;
  logic        rx_now, rx_next, byte_end, again;

  // Pin inputs: three stages, a change counts once stages two and three agree
  always_comb begin
    dq_f_nxt = (dq_s2_r == dq_s3_r) ? dq_s3_r : dq_f_r;
  end

  always_ff @(posedge clock_i) begin
    dq_s1_r <= dq_i;
    dq_s2_r <= dq_s1_r;
    dq_s3_r <= dq_s2_r;
    dq_f_r  <= dq_f_nxt;
  end

  // Frame list for each operation; step selects the frame
  always_comb begin
    f_code = `SFC_CODE_ST_READ;
    f_quad = quad_r;
    f_two  = 1'b0;
    f_nby  = 3'h1;
    f_poll = 1'b0;
    f_wait = 1'b0;
    f_last = 1'b1;
    unique case (op_r)
      OP_QUAD_ENTER: begin
        f_code = `SFC_CODE_QUAD_ENTER;
        f_quad = 1'b0;
      end
      OP_QUAD_EXIT: begin
        f_code = `SFC_CODE_QUAD_EXIT;
        f_quad = 1'b1;
        f_last = (step_r == 2'h1) | ~cont_r;
      end
      OP_RESET: begin
        // Arm and execute in separate frames, nothing in between
        f_code = step_r[0] ? `SFC_CODE_RST_EXEC : `SFC_CODE_RST_ARM;
        f_wait = step_r[0];
        f_last = step_r[0];
      end
      OP_RESET_BLIND: begin
        f_code = step_r[0] ? `SFC_CODE_RST_EXEC : `SFC_CODE_RST_ARM;
        f_quad = ~step_r[1];
        f_wait = step_r[0];
        f_last = (step_r == 2'h3);
      end
      OP_WL_SET:  f_code = `SFC_CODE_WL_SET;
      OP_WL_CLR:  f_code = `SFC_CODE_WL_CLR;
      OP_ST_READ: f_nby  = 3'h2;
      OP_ST_WRITE: begin
        // A rejected write would leave busy clear, so polling still ends
        unique case (step_r)
          2'h0: begin
            f_code = `SFC_CODE_WL_SET;
            f_last = 1'b0;
          end
          2'h1: begin
            f_code = `SFC_CODE_ST_WRITE;
            f_two  = 1'b1;
            f_nby  = 3'h2;
            f_last = 1'b0;
          end
          default: begin
            f_nby  = 3'h2;
            f_poll = 1'b1;
          end
        endcase
      end
      OP_ID_READ: begin
        f_code = `SFC_CODE_ID_READ;
        f_nby  = 3'h4;
      end
      default: f_nby = 3'h1;
    endcase
  end

  // Main sequencer
  always_comb begin
    state_nxt = state_r;
    op_nxt    = op_r;
    step_nxt  = step_r;
    ph_nxt    = ph_r;
    bit_nxt   = bit_r;
    bi_nxt    = bi_r;
    tsr_nxt   = tsr_r;
    rsr_nxt   = rsr_r;
    wait_nxt  = wait_r;
    wdat_nxt  = wdat_r;
    cont_nxt  = cont_r;
    bad_nxt   = bad_r;
    quad_nxt  = quad_r;
    stat_nxt  = stat_r;
    id_nxt    = id_r;
    done_nxt  = 1'b0;
    err_nxt   = 1'b0;
    cs_n_nxt  = cs_n_r;
    rx_now    = (bi_r != 3'h0) && !(f_two && bi_r == 3'h1);
    byte_end  = (bit_r == (f_quad ? 3'h1 : 3'h7));
    byte_in   = f_quad ? {rsr_r[3:0], dq_f_r} : {rsr_r[6:0], dq_f_r[1]};
    again     = f_poll & rx_now & byte_in[`SFC_ST_BUSY];
    unique case (state_r)
      ST_IDLE: begin
        if (cmd_valid_i && ready_r) begin
          op_nxt   = cmd_op_i;
          wdat_nxt = cmd_data_i;
          cont_nxt = cont_read_i;
          step_nxt = 2'h0;
          bad_nxt  = ((cmd_op_i == OP_QUAD_EXIT) && !quad_r) ||
                     ((cmd_op_i == OP_QUAD_ENTER) && quad_r);
          wait_nxt = 12'(`SFC_GAP_CYC);
          state_nxt = bad_nxt ? ST_FIN : ST_GAP;
        end
      end
      ST_GAP: begin
        if (wait_r == 12'h000) begin
          state_nxt = ST_SHIFT;
          ph_nxt    = 3'h0;
          bit_nxt   = 3'h0;
          bi_nxt    = 3'h0;
          tsr_nxt   = f_code;
          cs_n_nxt  = 1'b0;
        end else begin
          wait_nxt = wait_r - 12'h001;
        end
      end
      ST_SHIFT: begin
        ph_nxt = 3'(ph_r + 3'h1);
        if (ph_r == `SFC_PH_LAST) begin
          tsr_nxt = f_quad ? {tsr_r[3:0], 4'h0} : {tsr_r[6:0], 1'b0};
          rsr_nxt = byte_in;
          bit_nxt = byte_end ? 3'h0 : 3'(bit_r + 3'h1);
          if (byte_end) begin
            if (rx_now && op_r == OP_ID_READ) begin
              id_nxt = {id_r[15:0], byte_in};
            end else if (rx_now) begin
              stat_nxt = byte_in;
            end
            if ((bi_r == 3'(f_nby - 3'h1)) && !again) begin
              cs_n_nxt = 1'b1;
              wait_nxt = f_wait ? 12'(`SFC_RECOV_CYC) : 12'(`SFC_GAP_CYC);
              if (f_wait) begin
                state_nxt = ST_RECOV;
              end else if (f_last) begin
                state_nxt = ST_FIN;
              end else begin
                step_nxt  = 2'(step_r + 2'h1);
                state_nxt = ST_GAP;
              end
            end else if (!again) begin
              bi_nxt = 3'(bi_r + 3'h1);
              if (f_two && bi_r == 3'h0) begin
                tsr_nxt = wdat_r;
              end
            end
          end
        end
      end
      ST_RECOV: begin
        // Recovery wait covers the slowest case, an interrupted erase
        if (wait_r == 12'h000) begin
          stat_nxt = `SFC_ST_RESET;
          quad_nxt = 1'b0;
          wait_nxt = 12'(`SFC_GAP_CYC);
          if (f_last) begin
            state_nxt = ST_FIN;
          end else begin
            step_nxt  = 2'(step_r + 2'h1);
            state_nxt = ST_GAP;
          end
        end else begin
          wait_nxt = wait_r - 12'h001;
        end
      end
      ST_FIN: begin
        done_nxt  = 1'b1;
        err_nxt   = bad_r;
        state_nxt = ST_IDLE;
        if (!bad_r && op_r == OP_QUAD_ENTER) quad_nxt = 1'b1;
        if (!bad_r && op_r == OP_QUAD_EXIT) quad_nxt = 1'b0;
      end
    endcase
    ready_nxt = (state_nxt == ST_IDLE);
  end

  // Pin drive; data changes as select falls, then only as the serial clock falls
  always_comb begin
    rx_next  = (bi_nxt != 3'h0) && !(f_two && bi_nxt == 3'h1);
    sck_nxt  = (state_nxt == ST_SHIFT) && ph_nxt[2];
    if (state_nxt == ST_SHIFT && f_quad) begin
      dqo_nxt  = tsr_nxt[7:4];
      dqoe_nxt = rx_next ? 4'h0 : `SFC_DQ_QUAD_OE;
    end else begin
      // Protect and hold lanes held high in single-bit mode
      dqo_nxt  = {2'b11, 1'b0, tsr_nxt[7]};
      dqoe_nxt = `SFC_DQ_SINGLE_OE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_r <= ST_IDLE;
      op_r    <= OP_ST_READ;
      step_r  <= 2'h0;
      ph_r    <= 3'h0;
      bit_r   <= 3'h0;
      bi_r    <= 3'h0;
      tsr_r   <= 8'h00;
      rsr_r   <= 8'h00;
      wait_r  <= 12'h000;
      wdat_r  <= 8'h00;
      cont_r  <= 1'b0;
      bad_r   <= 1'b0;
      quad_r  <= 1'b0;
      stat_r  <= `SFC_ST_RESET;
      id_r    <= 24'h000000;
      ready_r <= 1'b0;
      done_r  <= 1'b0;
      err_r   <= 1'b0;
      sck_r   <= 1'b0;
      cs_n_r  <= 1'b1;
      dqo_r   <= `SFC_DQ_IDLE;
      dqoe_r  <= `SFC_DQ_SINGLE_OE;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      step_r  <= step_nxt;
      ph_r    <= ph_nxt;
      bit_r   <= bit_nxt;
      bi_r    <= bi_nxt;
      tsr_r   <= tsr_nxt;
      rsr_r   <= rsr_nxt;
      wait_r  <= wait_nxt;
      wdat_r  <= wdat_nxt;
      cont_r  <= cont_nxt;
      bad_r   <= bad_nxt;
      quad_r  <= quad_nxt;
      stat_r  <= stat_nxt;
      id_r    <= id_nxt;
      ready_r <= ready_nxt;
      done_r  <= done_nxt;
      err_r   <= err_nxt;
      sck_r   <= sck_nxt;
      cs_n_r  <= cs_n_nxt;
      dqo_r   <= dqo_nxt;
      dqoe_r  <= dqoe_nxt;
    end
  end

  assign cmd_ready_o = ready_r;
  assign done_o      = done_r;
  assign error_o     = err_r;
  assign status_o    = stat_r;
  assign id_o        = id_r;
  assign quad_mode_o = quad_r;
  assign sck_o       = sck_r;
  assign cs_n_o      = cs_n_r;
  assign dq_o        = dqo_r;
  assign dq_oe_o     = dqoe_r;
endmodule

// ===== sim/sfc_ctrl_asserts.sv
`timescale 1ns/1ns
module sfc_ctrl_asserts
  import sfc_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        srst_i,
  input wire logic        cmd_valid_i,
  input wire sfc_op_e     cmd_op_i,
  input wire logic [7:0]  cmd_data_i,
  input wire logic        cont_read_i,
  input wire logic        cmd_ready_o,
  input wire logic        done_o,
  input wire logic        error_o,
  input wire logic [7:0]  status_o,
  input wire logic [23:0] id_o,
  input wire logic        quad_mode_o,
  input wire logic        sck_o,
  input wire logic        cs_n_o,
  input wire logic [3:0]  dq_o,
  input wire logic [3:0]  dq_oe_o,
  input wire logic [3:0]  dq_i
);
  sfc_op_e op_r;
  sfc_op_e op_nxt;
  logic    take;
  assign take = cmd_valid_i && cmd_ready_o;
  always_comb begin
    op_nxt = take ? cmd_op_i : op_r;
  end
  always_ff @(posedge clock_i) begin
    op_r <= op_nxt;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sck_idle_a: assert property (cs_n_o |-> !sck_o)
    else $error("serial clock high outside frame");
  sck_high_a: assert property ($rose(sck_o) |-> sck_o[*4] ##1 !sck_o)
    else $error("serial clock high phase length");
  frame_gap_a: assert property ($rose(cs_n_o) |-> cs_n_o[*5])
    else $error("select high gap too short");
  take_busy_a: assert property (take |=> !cmd_ready_o && !done_o)
    else $error("ready after take");
  exit_refuse_a: assert property (take && cmd_op_i == OP_QUAD_EXIT
    && !quad_mode_o |=> cs_n_o ##1 (cs_n_o && done_o && error_o))
    else $error("exit in single mode not refused");
  enter_refuse_a: assert property (take && cmd_op_i == OP_QUAD_ENTER
    && quad_mode_o |-> ##2 (done_o && error_o))
    else $error("enter in quad mode not refused");
  enter_ok_a: assert property (done_o && !error_o
    && op_r == OP_QUAD_ENTER |-> ##[0:1] quad_mode_o)
    else $error("quad mode not entered");
  exit_ok_a: assert property (done_o && !error_o
    && op_r == OP_QUAD_EXIT |-> ##[0:1] !quad_mode_o)
    else $error("quad mode not left");
  reset_clr_a: assert property (done_o && op_r == OP_RESET
    |-> ##[0:1] (status_o == 8'h00 && !quad_mode_o))
    else $error("reset did not clear state");
  err_pair_a: assert property (error_o |-> done_o && cmd_ready_o)
    else $error("error without done");
endmodule

bind sfc_ctrl sfc_ctrl_asserts u_chk (
  .clock_i(clock_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_op_i(cmd_op_i), .cmd_data_i(cmd_data_i), .cont_read_i(cont_read_i),
  .cmd_ready_o(cmd_ready_o), .done_o(done_o), .error_o(error_o),
  .status_o(status_o), .id_o(id_o), .quad_mode_o(quad_mode_o),
  .sck_o(sck_o), .cs_n_o(cs_n_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
  .dq_i(dq_i)
);

// ===== sim/sfc_flash_model.sv
`timescale 1ns/1ns
module sfc_flash_model #(
  parameter logic [7:0]  MAN_CODE = 8'hA5,   // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h5A3C  // Arbitrary value
) (
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic [3:0] dq_i,
  input  wire logic       cont_i,
  output logic      [3:0] dq_o,
  output logic      [3:0] dq_oe_o
);
  logic       quad, cont, armed, write_latch_flag, rd;
  logic [5:0] nv;
  logic [7:0] op, sh, tx, dat;
  int         bits, nb, ob, busy, idx;
  initial begin
    quad = 0; cont = 0; armed = 0; write_latch_flag = 0; nv = 0; busy = 0; op = 0;
    dq_o = 0; dq_oe_o = 0; rd = 0;
  end
  always @(posedge cont_i) cont = 1;
  // Partial opcodes leave op at zero, so a quad-width frame sent to the model in single mode is ignored
  always @(negedge cs_n_i) begin
    bits = 0; nb = 0; rd = 0; ob = 0; idx = 0; op = 0;
  end
  always @(posedge sck_i) if (!cs_n_i) begin
    sh = quad ? {sh[3:0], dq_i} : {sh[6:0], dq_i[0]};
    bits += quad ? 4 : 1;
    if (bits == 8) begin
      bits = 0;
      if (nb == 0) op = sh; else dat = sh;
      nb++;
      rd = (op == 8'h05 || op == 8'h9F);
    end
  end
  always @(negedge sck_i) if (!cs_n_i && rd) begin
    if (ob == 0) begin
      if (op == 8'h05) begin
        tx = {nv, write_latch_flag, busy != 0};
        if (busy > 0) begin
          busy--;
          if (busy == 0) write_latch_flag = 0;
        end
      end else begin
        tx = 8'({MAN_CODE, DEV_CODE} >> (16 - 8 * idx));
        idx++;
      end
      ob = quad ? 2 : 8;
    end
    dq_oe_o = quad ? 4'hF : 4'h2;
    dq_o = quad ? tx[7:4] : {2'b00, tx[7], 1'b0};
    tx = quad ? tx << 4 : tx << 1;
    ob--;
  end
  always @(posedge cs_n_i) begin
    dq_oe_o = 0;
    rd = 0;
    if (armed && op == 8'h99) begin
      quad = 0; cont = 0; write_latch_flag = 0; nv = 0; busy = 0;
    end else case (op)
      8'h38: quad = 1;
      8'hFF: if (cont) cont = 0; else quad = 0;
      8'h06: write_latch_flag = 1;
      8'h04: write_latch_flag = 0;
      8'h01: if (write_latch_flag && nb == 2) begin
        nv = dat[7:2];
        busy = 2;
      end
      default: ;
    endcase
    armed = (op == 8'h66);
  end
endmodule

// ===== sim/test_sfc_ctrl.sv
`timescale 1ns/1ns
module test_sfc_ctrl
  import sfc_pkg::*;
;
  logic        clock_i, srst_i, cmd_valid_i, cont_read_i, mc, last_err;
  logic        cmd_ready_o, done_o, error_o, quad_mode_o, sck_o, cs_n_o;
  sfc_op_e     cmd_op_i;
  logic [7:0]  cmd_data_i, status_o;
  logic [23:0] id_o;
  logic [3:0]  dq_o, dq_oe_o, dq_i, m_dq, m_oe;
  int          err_count, checks, cyc;
  // Undriven lanes show the inverse of the host value, never a stale level
  assign dq_i = (dq_oe_o & dq_o) | (~dq_oe_o & m_oe & m_dq)
              | (~dq_oe_o & ~m_oe & ~dq_o);
  sfc_ctrl dut (.clock_i(clock_i), .srst_i(srst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .cmd_data_i(cmd_data_i), .cont_read_i(cont_read_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .error_o(error_o),
    .status_o(status_o), .id_o(id_o), .quad_mode_o(quad_mode_o),
    .sck_o(sck_o), .cs_n_o(cs_n_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .dq_i(dq_i));
  sfc_flash_model m (.sck_i(sck_o), .cs_n_i(cs_n_o), .dq_i(dq_i),
    .cont_i(mc), .dq_o(m_dq), .dq_oe_o(m_oe));

  task automatic report_and_stop();
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic run(input sfc_op_e op, input logic [7:0] d, input logic c);
    int n;
    n = 0;
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    cmd_data_i <= d;
    cont_read_i <= c;
    do @(posedge clock_i); while (cmd_ready_o !== 1'b1);
    cmd_valid_i <= 1'b0;
    do begin
      @(posedge clock_i);
      n++;
    end while (done_o !== 1'b1 && n < 20000);
    if (done_o !== 1'b1) err_count++;
    last_err = error_o;
  endtask
  task automatic t_exit_single();
    run(OP_QUAD_EXIT, 8'h00, 1'b0);
    chk("exit_err", 24'h1, last_err);
    chk("exit_mode", 24'h0, quad_mode_o);
  endtask
  task automatic t_latch();
    run(OP_WL_SET, 8'h00, 1'b0);
    run(OP_ST_READ, 8'h00, 1'b0);
    chk("wl_set", 24'h02, status_o);
    run(OP_WL_CLR, 8'h00, 1'b0);
    run(OP_ST_READ, 8'h00, 1'b0);
    chk("wl_clr", 24'h00, status_o);
  endtask
  task automatic t_write();
    run(OP_ST_WRITE, 8'hB4, 1'b0);
    chk("wr_poll", 24'hB4, status_o);
    run(OP_ST_READ, 8'h00, 1'b0);
    chk("wr_read", 24'hB4, status_o);
  endtask
  task automatic t_id();
    run(OP_ID_READ, 8'h00, 1'b0);
    chk("id", 24'hA55A3C, id_o);
  endtask
  task automatic t_quad();
    run(OP_QUAD_ENTER, 8'h00, 1'b0);
    chk("q_mode", 24'h1, quad_mode_o);
    chk("q_dev", 24'h1, m.quad);
    run(OP_QUAD_ENTER, 8'h00, 1'b0);
    chk("q_again", 24'h1, last_err);
    run(OP_WL_SET, 8'h00, 1'b0);
    run(OP_ST_READ, 8'h00, 1'b0);
    chk("q_stat", 24'hB6, status_o);
    mc <= 1'b1;
    run(OP_QUAD_EXIT, 8'h00, 1'b1);
    chk("x_dev", 24'h0, m.quad);
    chk("x_mode", 24'h0, quad_mode_o);
    run(OP_QUAD_ENTER, 8'h00, 1'b0);
    run(OP_QUAD_EXIT, 8'h00, 1'b0);
    chk("x2_dev", 24'h0, m.quad);
  endtask
  task automatic t_reset();
    int t0;
    run(OP_QUAD_ENTER, 8'h00, 1'b0);
    run(OP_WL_SET, 8'h00, 1'b0);
    t0 = cyc;
    run(OP_RESET, 8'h00, 1'b0);
    // Recovery of 28 us is 2800 clocks at 100 MHz
    chk("r_wait", 24'h1, (cyc - t0) > 2800);
    chk("r_stat", 24'h00, status_o);
    chk("r_mode", 24'h0, quad_mode_o);
    chk("r_dev", 24'h0, m.quad);
    run(OP_ST_READ, 8'h00, 1'b0);
    chk("r_read", 24'h00, status_o);
  endtask
  task automatic t_blind();
    run(OP_QUAD_ENTER, 8'h00, 1'b0);
    run(OP_WL_SET, 8'h00, 1'b0);
    run(OP_RESET_BLIND, 8'h00, 1'b0);
    chk("b_mode", 24'h0, quad_mode_o);
    run(OP_ST_READ, 8'h00, 1'b0);
    chk("b_read", 24'h00, status_o);
    chk("b_dev", 24'h0, m.quad);
  endtask

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Ceiling covers three reset recoveries plus all frames with margin
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    srst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_op_i = OP_ST_READ;
    cmd_data_i = 8'h00;
    cont_read_i = 1'b0;
    mc = 1'b0;
    repeat (4) @(posedge clock_i);
    srst_i <= 1'b0;
    t_exit_single();
    t_latch();
    t_write();
    t_id();
    t_quad();
    t_reset();
    t_blind();
    report_and_stop();
  end
endmodule
